// [apmc_pkg.sv]
/*
 Constants, register map and types for the audio path mode control block.
 Assumes a 200 MHz clock and an Avalon-MM master issuing aligned word accesses.
*/
// Function
// - Exactly one of idle, receive, transmit
// - Reset enters idle without host action
// - Parameter programming writes accepted only in idle
// - Voice from path one; signalling routable
// - Transmit output destinations follow routing settings
// - Selectable narrow or wide channel filter, limiter
// - Stage order selectable, each stage enabled; limiter follows channel filter
// - Receive high-pass, narrow and wide low-pass
// - No filter selected means bypassed path
// - Receive de-emphasis when selected
// - Transmit pre-emphasis with either channel filter
// - Inversion frequency default, parameter word changes it
// - Transmit high-pass when enabled
// - Audio output at bias before switching
// - Ramp modulator outputs when ramp enabled
// - Disabled output at bias, powered-down floats
// - AGC records gain, steps down while loud
// - AGC steps gain back up to recorded
// - AGC word enables AGC, selects detector
// - Controls sampled once per latency period
package apmc_pkg;
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          LATENCY_US    = 250;
    localparam int          LATENCY_CYC   = LATENCY_US * 1000000 / CLK_PERIOD_PS;
    localparam int          LAT_W         = 17;
    localparam int          ADDR_W        = 5;

    localparam logic [4:0]  OFS_MODE   = 5'h00;
    localparam logic [4:0]  OFS_AUDIO  = 5'h04;
    localparam logic [4:0]  OFS_ROUTE  = 5'h08;
    localparam logic [4:0]  OFS_GAIN   = 5'h0C;
    localparam logic [4:0]  OFS_PROG   = 5'h10;
    localparam logic [4:0]  OFS_STATUS = 5'h14;

    // Audio control fields
    localparam int AU_HPF = 0, AU_EMPH = 1, AU_CHAN = 2, AU_WIDE = 3, AU_SCRAM = 4, AU_ORD = 5;
    // Routing fields
    localparam int RT_P1 = 0, RT_P2 = 2, RT_SIG = 4, RT_M1S = 8, RT_M2S = 10;
    localparam int RT_M1EN = 12, RT_M2EN = 13, RT_M1PD = 14, RT_M2PD = 15;
    // Gain fields
    localparam int GN_IN1 = 0, GN_RAMP = 7;
    // Programming fields and indices
    localparam int PR_IDX = 16;
    localparam logic [1:0] PIDX_RAMP = 2'h0;
    localparam logic [1:0] PIDX_INV  = 2'h1;
    localparam logic [1:0] PIDX_AGC  = 2'h2;
    // AGC word fields; rate in upper byte
    localparam int AG_EN = 0, AG_SRC = 1, AG_RATE = 8;
    // Status fields
    localparam int ST_REJ = 3;

    localparam logic [15:0] INV_FREQ_DEF = 16'h0CE4;
    localparam logic [15:0] RAMP_DEF     = 16'h0101;
    localparam logic [15:0] AGC_DEF      = 16'h1000;
    localparam logic [7:0]  RAMP_MAX     = 8'hFF;
    localparam logic [7:0]  RAMP_BIAS    = 8'h00;

    typedef enum logic [1:0] {
        APMC_IDLE = 2'b00,
        APMC_RX   = 2'b01,
        APMC_TX   = 2'b10
    } apmc_mode_t;

    typedef enum logic [0:0] {
        APMC_STEADY = 1'b0,
        APMC_DRAIN  = 1'b1
    } apmc_phase_t;
endpackage : apmc_pkg

// [apmc_top.sv]
/*
 Mode control and audio chain configuration: Avalon-MM register slave,
 latency-period sampling, mode sequencing, modulator ramps and input AGC.
 Assumes level detector flags arrive asynchronously from the analogue side.
*/
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module apmc_top #(
    parameter int LATENCY_CYCLES = apmc_pkg::LATENCY_CYC
) (
    input  wire logic                        clk,           // 200 MHz clock
    input  wire logic                        rstn,          // Async reset, low
    input  wire logic [apmc_pkg::ADDR_W-1:0] address,       // Byte address
    input  wire logic                        read,          // Read request
    input  wire logic                        write,         // Write request
    input  wire logic [31:0]                 writedata,     // Write data
    input  wire logic [3:0]                  byteenable,    // Byte lanes
    output logic                             waitrequest,   // Stall
    output logic [31:0]                      readdata,      // Read data
    input  wire logic                        agc_over_thr,  // Level above threshold
    input  wire logic                        agc_under_thr, // Level has dropped
    output logic [1:0]                       mode_state,    // Current mode
    output logic                             audio_at_bias, // Audio held at bias
    output logic [1:0]                       path1_pin_sel, // Input path one pin
    output logic [1:0]                       path2_pin_sel, // Input path two pin
    output logic [3:0]                       sig_path_sel,  // Signalling block paths
    output logic [1:0]                       modulator_output_one_src,      // Output one source
    output logic [1:0]                       modulator_output_two_src,      // Output two source
    output logic [7:0]                       modulator_output_one, // Level over bias
    output logic [7:0]                       modulator_output_two, // Level over bias
    output logic                             modulator_output_one_oe,       // Output one driven
    output logic                             modulator_output_two_oe,       // Output two driven
    output logic                             hpf_on,        // High-pass active
    output logic                             deemph_on,     // Receive de-emphasis
    output logic                             preemph_on,    // Transmit pre-emphasis
    output logic                             chan_filt_on,  // Channel filter active
    output logic                             chan_wide,     // Wide channel select
    output logic                             limiter_on,    // Soft limiter active
    output logic                             scram_on,      // Inversion active
    output logic [1:0]                       stage_order,   // Stage order code
    output logic [15:0]                      inversion_frequency_parameter, // Inversion
    output logic [3:0]                       in1_gain,      // Input one gain code
    output logic                             agc_src_sel    // Detector source
);
    import apmc_pkg::*;

    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        over_s1;
        logic        over_s2;
        logic        under_s1;
        logic        under_s2;
        logic [LAT_W-1:0] tick_cnt;
        logic [31:0] sh_mode;
        logic [31:0] sh_audio;
        logic [31:0] sh_route;
        logic [31:0] sh_gain;
        logic        gain_new;
        logic [31:0] ac_audio;
        logic [31:0] ac_route;
        logic        ramp_en;
        logic [15:0] ramp_word;
        logic [15:0] inv_freq;
        logic [15:0] agc_word;
        logic        prog_rej;
        apmc_mode_t  mode;
        apmc_mode_t  target;
        apmc_phase_t phase;
        logic [7:0]  ramp;
        logic [7:0]  ramp_cnt;
        logic [3:0]  gain;
        logic [3:0]  gain_rec;
        logic [7:0]  agc_cnt;
        logic        o_bias;
        logic [7:0]  o_modulator_output_one;
        logic [7:0]  o_modulator_output_two;
        logic        o_oe1;
        logic        o_oe2;
        logic        o_hpf;
        logic        o_deemph;
        logic        o_preemph;
        logic        o_chan;
        logic        o_scram;
        logic [1:0]  o_m1s;
        logic [1:0]  o_m2s;
    } apmc_state_t;

    apmc_state_t s;
    apmc_state_t n;
    logic        tick;
    logic        wr_fire;
    logic        active;
    logic        tx_run;
    logic [7:0]  ramp_goal;

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction : be_merge

    // Pin code 3 is not a pin; falls back to the first
    function automatic logic [1:0] pin_sel(input logic [1:0] v);
        return (v == 2'h3) ? 2'h0 : v;
    endfunction : pin_sel

    // Zero rate would stall forever, so it counts as one
    function automatic logic [7:0] rate_of(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction : rate_of

    function automatic apmc_mode_t to_mode(input logic [1:0] v, input apmc_mode_t cur);
        if (v == 2'b01)
            return APMC_RX;
        else if (v == 2'b10)
            return APMC_TX;
        else if (v == 2'b00)
            return APMC_IDLE;
        else
            return cur;
    endfunction : to_mode

    assign tick    = (s.tick_cnt == LAT_W'(LATENCY_CYCLES - 1));
    assign wr_fire = write && !s.waitreq;
    assign active  = (s.phase == APMC_STEADY) && (s.mode != APMC_IDLE);
    assign tx_run  = (s.phase == APMC_STEADY) && (s.mode == APMC_TX);
    assign ramp_goal = tx_run ? RAMP_MAX : RAMP_BIAS;

    always_comb
    begin
        n = s;
        n.over_s1  = agc_over_thr;
        n.over_s2  = s.over_s1;
        n.under_s1 = agc_under_thr;
        n.under_s2 = s.under_s1;
        n.tick_cnt = tick ? '0 : s.tick_cnt + LAT_W'(1);

        // One wait state: answer on the cycle after the request is seen
        n.waitreq = !((read || write) && s.waitreq);
        if (read && s.waitreq)
        begin
            if (address == OFS_MODE)
                n.rdata = s.sh_mode;
            else if (address == OFS_AUDIO)
                n.rdata = s.sh_audio;
            else if (address == OFS_ROUTE)
                n.rdata = s.sh_route;
            else if (address == OFS_GAIN)
                n.rdata = s.sh_gain;
            else if (address == OFS_STATUS)
                n.rdata = {16'h0000, s.ramp, s.gain, s.prog_rej,
                           s.phase == APMC_DRAIN, s.mode};
            else
                n.rdata = 32'h0000_0000;
        end

        if (wr_fire)
        begin
            if (address == OFS_MODE)
                n.sh_mode = be_merge(s.sh_mode, writedata, byteenable) & 32'h0000_0003;
            else if (address == OFS_AUDIO)
                n.sh_audio = be_merge(s.sh_audio, writedata, byteenable) & 32'h0000_007F;
            else if (address == OFS_ROUTE)
                n.sh_route = be_merge(s.sh_route, writedata, byteenable) & 32'h0000_FFFF;
            else if (address == OFS_GAIN)
            begin
                n.sh_gain  = be_merge(s.sh_gain, writedata, byteenable) & 32'h0000_008F;
                n.gain_new = 1'b1;
            end
            else if (address == OFS_STATUS)
            begin
                if (byteenable[0] && writedata[ST_REJ])
                    n.prog_rej = 1'b0;
            end
            else if (address == OFS_PROG)
            begin
                // Long-lived parameters may only change while idle
                if (s.mode == APMC_IDLE && s.phase == APMC_STEADY)
                begin
                    if (writedata[PR_IDX +: 2] == PIDX_RAMP)
                        n.ramp_word = writedata[15:0];
                    else if (writedata[PR_IDX +: 2] == PIDX_INV)
                        n.inv_freq = writedata[15:0];
                    else if (writedata[PR_IDX +: 2] == PIDX_AGC)
                        n.agc_word = writedata[15:0];
                end
                else
                    n.prog_rej = 1'b1;
            end
        end

        // Mode, audio, routing and gain settings reach the processing chain only at period end
        if (tick)
        begin
            n.ac_audio = s.sh_audio;
            n.ac_route = s.sh_route;
            // Pin code folded here so the selects come straight off flops
            n.ac_route[RT_P1 +: 2] = pin_sel(s.sh_route[RT_P1 +: 2]);
            n.ac_route[RT_P2 +: 2] = pin_sel(s.sh_route[RT_P2 +: 2]);
            n.ramp_en  = s.sh_gain[GN_RAMP];
            if (s.gain_new && !(wr_fire && address == OFS_GAIN))
            begin
                n.gain     = s.sh_gain[GN_IN1 +: 4];
                n.gain_new = 1'b0;
            end
            if (s.phase == APMC_STEADY && to_mode(s.sh_mode[1:0], s.mode) != s.mode)
            begin
                n.target = to_mode(s.sh_mode[1:0], s.mode);
                n.phase  = APMC_DRAIN;
            end
        end

        // Modulator ramp toward bias or full level
        if (!s.ramp_en)
        begin
            n.ramp     = ramp_goal;
            n.ramp_cnt = 8'h00;
        end
        else if (s.ramp != ramp_goal)
        begin
            if (s.ramp_cnt >= rate_of(tx_run ? s.ramp_word[7:0] : s.ramp_word[15:8]) - 8'h01)
            begin
                n.ramp_cnt = 8'h00;
                n.ramp     = tx_run ? s.ramp + 8'h01 : s.ramp - 8'h01;
            end
            else
                n.ramp_cnt = s.ramp_cnt + 8'h01;
        end
        else
            n.ramp_cnt = 8'h00;

        // Switch only once audio and the modulator ramp already sit at bias
        if (s.phase == APMC_DRAIN && s.ramp == RAMP_BIAS && s.o_bias)
        begin
            n.mode  = s.target;
            n.phase = APMC_STEADY;
            n.agc_cnt = 8'h00;
            if (s.target == APMC_TX)
                n.gain_rec = s.gain;
        end

        // Input AGC, one gain code per step
        if (tx_run && s.agc_word[AG_EN])
        begin
            if (s.agc_cnt >= rate_of(s.agc_word[AG_RATE +: 8]) - 8'h01)
            begin
                n.agc_cnt = 8'h00;
                if (s.over_s2 && s.gain != 4'h0)
                    n.gain = s.gain - 4'h1;
                else if (!s.over_s2 && s.under_s2 && s.gain < s.gain_rec)
                    n.gain = s.gain + 4'h1;
            end
            else
                n.agc_cnt = s.agc_cnt + 8'h01;
        end

        // Registered outputs
        n.o_bias    = !(s.phase == APMC_STEADY && s.mode == APMC_RX);
        n.o_modulator_output_one    = s.ac_route[RT_M1EN] ? s.ramp : RAMP_BIAS;
        n.o_modulator_output_two    = s.ac_route[RT_M2EN] ? s.ramp : RAMP_BIAS;
        n.o_oe1     = !s.ac_route[RT_M1PD];
        n.o_oe2     = !s.ac_route[RT_M2PD];
        n.o_m1s     = tx_run ? s.ac_route[RT_M1S +: 2] : 2'h0;
        n.o_m2s     = tx_run ? s.ac_route[RT_M2S +: 2] : 2'h0;
        n.o_hpf     = active && s.ac_audio[AU_HPF];
        n.o_deemph  = active && s.mode == APMC_RX && s.ac_audio[AU_EMPH];
        n.o_preemph = tx_run && s.ac_audio[AU_EMPH];
        n.o_chan    = active && s.ac_audio[AU_CHAN];
        n.o_scram   = active && s.ac_audio[AU_SCRAM];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s           <= '0;
            s.waitreq   <= 1'b1;
            s.mode      <= APMC_IDLE;
            s.target    <= APMC_IDLE;
            s.phase     <= APMC_STEADY;
            s.o_bias    <= 1'b1;
            s.ramp_word <= RAMP_DEF;
            s.inv_freq  <= INV_FREQ_DEF;
            s.agc_word  <= AGC_DEF;
        end
        else
            s <= n;
    end

    assign waitrequest   = s.waitreq;
    assign readdata      = s.rdata;
    assign mode_state    = s.mode;
    assign audio_at_bias = s.o_bias;
    // Voice blocks have no selector: they always read path one
    assign path1_pin_sel = s.ac_route[RT_P1 +: 2];
    assign path2_pin_sel = s.ac_route[RT_P2 +: 2];
    assign sig_path_sel  = s.ac_route[RT_SIG +: 4];
    assign modulator_output_one_src      = s.o_m1s;
    assign modulator_output_two_src      = s.o_m2s;
    assign modulator_output_one = s.o_modulator_output_one;
    assign modulator_output_two = s.o_modulator_output_two;
    assign modulator_output_one_oe       = s.o_oe1;
    assign modulator_output_two_oe       = s.o_oe2;
    assign hpf_on        = s.o_hpf;
    assign deemph_on     = s.o_deemph;
    assign preemph_on    = s.o_preemph;
    assign chan_filt_on  = s.o_chan;
    assign chan_wide     = s.ac_audio[AU_WIDE];
    assign limiter_on    = s.o_chan;
    assign scram_on      = s.o_scram;
    assign stage_order   = s.ac_audio[AU_ORD +: 2];
    assign inversion_frequency_parameter = s.inv_freq;
    assign in1_gain      = s.gain;
    assign agc_src_sel   = s.agc_word[AG_SRC];
endmodule : apmc_top

// [apmc_asserts.sv]
/*
 Port-level checks for the audio path mode control block.
 Bound to apmc_top from the testbench file; one clock domain.
*/
`timescale 1ns/1ps
module apmc_asserts (
    input wire logic        clk,                  // Clock
    input wire logic        rstn,                 // Async reset, low
    input wire logic        read,                 // Read request
    input wire logic        write,                // Write request
    input wire logic        waitrequest,          // Stall
    input wire logic [31:0] readdata,             // Read data
    input wire logic [1:0]  mode_state,           // Current mode
    input wire logic        audio_at_bias,        // Audio held at bias
    input wire logic [1:0]  modulator_output_one_src,             // Output one source
    input wire logic [7:0]  modulator_output_one, // Level over bias
    input wire logic [7:0]  modulator_output_two, // Level over bias
    input wire logic        deemph_on,            // Receive de-emphasis
    input wire logic        preemph_on,           // Transmit pre-emphasis
    input wire logic [3:0]  in1_gain              // Input one gain
);
    import apmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_one_mode;
        mode_state != 2'h3;
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("mode code out of range");
    property p_one_wait;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer not one cycle");
    property p_rdata_hold;
        !read |=> $stable(readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_switch_bias;
        mode_state != $past(mode_state) |-> $past(audio_at_bias);
    endproperty
    a_switch_bias: assert property (p_switch_bias) else $error("mode switched off bias");
    property p_audio_rx;
        !audio_at_bias |-> mode_state == APMC_RX;
    endproperty
    a_audio_rx: assert property (p_audio_rx) else $error("audio live outside rx");
    property p_idle_quiet;
        mode_state == APMC_IDLE |-> modulator_output_one == 8'h00 && modulator_output_two == 8'h00;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("modulator live in idle");
    property p_deemph_rx;
        deemph_on |-> mode_state == APMC_RX;
    endproperty
    a_deemph_rx: assert property (p_deemph_rx) else $error("de-emphasis outside rx");
    property p_preemph_tx;
        preemph_on || modulator_output_one_src != 2'h0 |-> mode_state == APMC_TX;
    endproperty
    a_preemph_tx: assert property (p_preemph_tx) else $error("tx path outside tx");
    property p_gain_step;
        mode_state == APMC_TX && $past(mode_state) == APMC_TX && in1_gain != $past(in1_gain)
            |-> in1_gain == $past(in1_gain) + 4'h1 || in1_gain == $past(in1_gain) - 4'h1;
    endproperty
    a_gain_step: assert property (p_gain_step) else $error("gain jumped");
endmodule : apmc_asserts

// [apmc_host_model.sv]
/*
 Host side model: Avalon-MM master tasks and the input level detector.
 Assumes one clock shared with the slave and a one-cycle answer or longer.
*/
`timescale 1ns/1ps
module apmc_host_model (
    input  wire logic                        clk,           // Clock
    input  wire logic                        waitrequest,   // Slave stall
    input  wire logic [31:0]                 readdata,      // Read data
    output logic      [apmc_pkg::ADDR_W-1:0] address,       // Byte address
    output logic                             read,          // Read request
    output logic                             write,         // Write request
    output logic      [31:0]                 writedata,     // Write data
    output logic      [3:0]                  byteenable,    // Byte lanes
    output logic                             agc_over_thr,  // Level above threshold
    output logic                             agc_under_thr  // Level has dropped
);
    import apmc_pkg::*;
    initial
    begin
        {address, read, write, writedata, byteenable} = '0;
        {agc_over_thr, agc_under_thr} = 2'h0;
    end
    // Stall read right after the edge: the value the slave saw there
    task automatic wait_ans();
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'b0);
    endtask : wait_ans
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        wait_ans();
        write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        wait_ans();
        d = readdata;
        read <= 1'b0;
    endtask : rd
    task automatic set_level(input logic over, input logic under);
        @(posedge clk);
        agc_over_thr <= over;
        agc_under_thr <= under;
    endtask : set_level
endmodule : apmc_host_model

// [testbench.sv]
/*
 Self-checking bench for apmc_top: register sequences through the host model.
 Assumes a shortened latency period of LAT cycles.
*/
`timescale 1ns/1ps
module testbench;
    import apmc_pkg::*;
    localparam int LAT = 16;
    logic clk, rstn, read, write, waitrequest, agc_over_thr, agc_under_thr;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, rdata;
    logic [3:0] byteenable, sig_path_sel, in1_gain;
    logic [1:0] mode_state, path1_pin_sel, path2_pin_sel, modulator_output_one_src, modulator_output_two_src, stage_order;
    logic [7:0] modulator_output_one, modulator_output_two;
    logic [15:0] inversion_frequency_parameter;
    logic audio_at_bias, modulator_output_one_oe, modulator_output_two_oe, hpf_on, deemph_on, preemph_on, chan_filt_on;
    logic chan_wide, limiter_on, scram_on, agc_src_sel;
    int fails, n_tests;

    apmc_top #(.LATENCY_CYCLES(LAT)) dut (.clk(clk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .waitrequest(waitrequest), .readdata(readdata), .agc_over_thr(agc_over_thr),
        .agc_under_thr(agc_under_thr), .mode_state(mode_state), .audio_at_bias(audio_at_bias),
        .path1_pin_sel(path1_pin_sel), .path2_pin_sel(path2_pin_sel),
        .sig_path_sel(sig_path_sel), .modulator_output_one_src(modulator_output_one_src), .modulator_output_two_src(modulator_output_two_src),
        .modulator_output_one(modulator_output_one), .modulator_output_two(modulator_output_two),
        .modulator_output_one_oe(modulator_output_one_oe), .modulator_output_two_oe(modulator_output_two_oe), .hpf_on(hpf_on), .deemph_on(deemph_on),
        .preemph_on(preemph_on), .chan_filt_on(chan_filt_on), .chan_wide(chan_wide),
        .limiter_on(limiter_on), .scram_on(scram_on), .stage_order(stage_order),
        .inversion_frequency_parameter(inversion_frequency_parameter),
        .in1_gain(in1_gain), .agc_src_sel(agc_src_sel));
    apmc_host_model u_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .agc_over_thr(agc_over_thr), .agc_under_thr(agc_under_thr));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // Controls land at the next period end, within one latency period of the write
    task automatic wait_ticks(input int n);
        repeat (n * LAT + 4) @(negedge clk);
    endtask : wait_ticks
    task automatic wait_mode(input logic [1:0] m);
        for (int i = 0; i < 3000 && mode_state !== m; i++) @(negedge clk);
    endtask : wait_mode
    task automatic wait_gain(input logic [3:0] g);
        for (int i = 0; i < 400 && in1_gain !== g; i++) @(negedge clk);
    endtask : wait_gain
    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        test_done();
    end

    initial
    begin
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({mode_state, audio_at_bias, waitrequest}, {2'h0, 1'h1, 1'h1});
        chk(inversion_frequency_parameter, INV_FREQ_DEF);
        // Long-lived words first, while still idle
        u_host.wr(OFS_PROG, {14'h0, PIDX_INV, 16'h1234}, 4'hF);
        wait_ticks(1);
        u_host.wr(OFS_PROG, {14'h0, PIDX_AGC, 16'h0103}, 4'hF);
        u_host.wr(OFS_AUDIO, 32'h0000_005F, 4'hF);
        u_host.wr(OFS_ROUTE, 32'h0000_39A9, 4'hF);
        u_host.wr(OFS_GAIN, 32'h0000_0088, 4'hF);
        wait_ticks(2);
        chk({inversion_frequency_parameter, agc_src_sel}, {16'h1234, 1'h1});
        u_host.wr(OFS_MODE, 32'h0000_0001, 4'hF);
        wait_mode(APMC_RX);
        wait_ticks(1);
        chk({deemph_on, preemph_on, hpf_on, chan_filt_on, chan_wide, limiter_on, scram_on,
            stage_order, path1_pin_sel, path2_pin_sel, sig_path_sel, audio_at_bias, modulator_output_one_src},
            {7'h5F, 2'h2, 2'h1, 2'h2, 4'hA, 1'h0, 2'h0});
        // Refused outside idle, flag is sticky until cleared
        u_host.wr(OFS_PROG, {14'h0, PIDX_INV, 16'h0AAA}, 4'hF);
        u_host.rd(OFS_STATUS, rdata);
        chk({rdata[3], inversion_frequency_parameter}, {1'h1, 16'h1234});
        u_host.wr(OFS_STATUS, 32'h0000_0008, 4'h1);
        u_host.rd(OFS_STATUS, rdata);
        chk(rdata[3], 1'h0);
        u_host.wr(OFS_GAIN, 32'h0000_0088, 4'hF);
        wait_ticks(1);
        u_host.wr(OFS_MODE, 32'h0000_0002, 4'hF);
        wait_mode(APMC_TX);
        for (int i = 0; i < 1000 && modulator_output_one !== 8'hFF; i++) @(negedge clk);
        chk({modulator_output_one, modulator_output_two}, 16'hFFFF);
        chk({modulator_output_one_src, modulator_output_two_src, preemph_on, deemph_on, hpf_on, in1_gain},
            {2'h1, 2'h2, 1'h1, 1'h0, 1'h1, 4'h8});
        u_host.rd(OFS_STATUS, rdata);
        chk(rdata[7:0], 8'h82);
        // Unmapped word must not echo the previous read
        u_host.rd(5'h1C, rdata);
        chk(rdata, 32'h0000_0000);
        u_host.set_level(1'b1, 1'b0);
        wait_gain(4'h0);
        chk(in1_gain, 4'h0);
        u_host.set_level(1'b0, 1'b1);
        wait_gain(4'h8);
        repeat (40) @(negedge clk);
        chk(in1_gain, 4'h8);
        u_host.set_level(1'b0, 1'b0);
        u_host.wr(OFS_MODE, 32'h0000_0000, 4'hF);
        wait_mode(APMC_IDLE);
        chk({modulator_output_one, modulator_output_two, audio_at_bias, hpf_on, chan_filt_on},
            {16'h0000, 1'h1, 2'h0});
        u_host.wr(OFS_ROUTE, 32'h0000_79A9, 4'hF);
        wait_ticks(2);
        chk({modulator_output_one_oe, modulator_output_two_oe}, 2'h1);
        test_done();
    end
endmodule : testbench

bind apmc_top apmc_asserts u_chk (.clk(clk), .rstn(rstn), .read(read), .write(write),
    .waitrequest(waitrequest), .readdata(readdata), .mode_state(mode_state),
    .audio_at_bias(audio_at_bias), .modulator_output_one_src(modulator_output_one_src),
    .modulator_output_one(modulator_output_one), .modulator_output_two(modulator_output_two),
    .deemph_on(deemph_on), .preemph_on(preemph_on), .in1_gain(in1_gain));
